// file: verilog/fsr_defines.svh
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH
// Summary of operation
// - 7-bit rx error vector, fixed bit meanings
// - rx error vector shown with rx strobe
// - rx error vector meaningless after overflow
// - tx strobe only for valid status word
// - tx word 40 bits: payload, packet length
// - bits 32-39 flag the frame types
// - tx word shown with tx strobe
// - tx word meaningless on underflow, crc/pad insertion
// - 7-bit tx error vector, fixed bit meanings
// - tx error vector shown with tx strobe
// - tx error vector meaningless then too
// - flow-control strobe only with qualified vector
// - rx strobe in the last-beat cycle
// - vector 2n wide: even xon, odd xoff

`define FSR_ERR_W 7
`define FSR_LEN_W 16
`define FSR_TYPE_W 8
`define FSR_TXW_W 40
`define FSR_PFC_QMAX 8
`define FSR_PFC_W 16
`define FSR_QCNT_W 4
`define FSR_ADDR_W 8
`define FSR_DATA_W 32
`define FSR_CNT_W 32

// error vector bit positions
`define FSR_RXE_UNDER 0
`define FSR_RXE_OVER 1
`define FSR_RXE_LEN 2
`define FSR_RXE_CRC 3
`define FSR_RXE_PHY 6
`define FSR_TXE_UNDER 0
`define FSR_TXE_OVER 1
`define FSR_TXE_LEN 2
`define FSR_TXE_UFLOW 4
`define FSR_TXE_CLIENT 5

// tx status word field positions
`define FSR_TXS_PAY_LSB 0
`define FSR_TXS_PKT_LSB 16
`define FSR_TXS_TYPE_LSB 32

// register byte offsets
`define FSR_OFS_CTRL 8'h00
`define FSR_OFS_IRQ_STAT 8'h04
`define FSR_OFS_IRQ_MASK 8'h08
`define FSR_OFS_RX_FRAMES 8'h0C
`define FSR_OFS_RX_ERRORS 8'h10
`define FSR_OFS_TX_FRAMES 8'h14
`define FSR_OFS_TX_ERRORS 8'h18
`define FSR_OFS_LAST_LEN 8'h1C
`define FSR_OFS_LAST_ERR 8'h20

// control register fields and reset
`define FSR_CTRL_SUPPRESS 0
`define FSR_CTRL_OVF_MASK 1
`define FSR_CTRL_Q_LSB 4
`define FSR_CTRL_RST 32'h0000_0080

// interrupt status bits
`define FSR_IRQ_RX_FRAME 0
`define FSR_IRQ_RX_ERROR 1
`define FSR_IRQ_RX_OVFL 2
`define FSR_IRQ_TX_FRAME 3
`define FSR_IRQ_TX_ERROR 4
`define FSR_IRQ_TX_UFLOW 5
`define FSR_IRQ_PFC 6
`define FSR_IRQ_W 7
`define FSR_IRQ_MASK_RST 7'h00

// last-status register field positions
`define FSR_LERR_TX_LSB 8
`define FSR_LERR_TYPE_LSB 16
`endif

// file: verilog/fsr_pkg.sv
`include "fsr_defines.svh"

package fsr_pkg;
    typedef logic [`FSR_ERR_W-1:0] fsr_err_vec_t;
    typedef logic [`FSR_LEN_W-1:0] fsr_len_t;
    typedef logic [`FSR_TYPE_W-1:0] fsr_type_t;
    typedef logic [`FSR_TXW_W-1:0] fsr_tx_word_t;
    typedef logic [`FSR_PFC_W-1:0] fsr_pfc_vec_t;
    typedef logic [`FSR_PFC_QMAX-1:0] fsr_queue_t;
    typedef logic [`FSR_ADDR_W-1:0] fsr_addr_t;
    typedef logic [`FSR_DATA_W-1:0] fsr_data_t;
    typedef logic [`FSR_CNT_W-1:0] fsr_cnt_t;
    typedef logic [`FSR_IRQ_W-1:0] fsr_irq_t;

    typedef enum logic [3:0] {
        FSR_SEL_CTRL = 4'h0,
        FSR_SEL_IRQ_STAT = 4'h1,
        FSR_SEL_IRQ_MASK = 4'h2,
        FSR_SEL_RX_FRAMES = 4'h3,
        FSR_SEL_RX_ERRORS = 4'h4,
        FSR_SEL_TX_FRAMES = 4'h5,
        FSR_SEL_TX_ERRORS = 4'h6,
        FSR_SEL_LAST_LEN = 4'h7,
        FSR_SEL_LAST_ERR = 4'h8,
        FSR_SEL_NONE = 4'hF
    } fsr_reg_sel_t;
endpackage

// file: verilog/fsr_evt_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"

module fsr_evt_counter (
    input wire logic i_clk, // client clock
    input wire logic i_rst, // synchronous reset
    input wire logic i_clr, // software clear
    input wire logic i_inc, // one count per pulse
    output fsr_pkg::fsr_cnt_t o_count // current count
);
    import fsr_pkg::*;

    // saturates instead of wrapping so a stuck link is not hidden
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_count <= '0;
        end else if (i_clr) begin
            // an event in the clear cycle is kept
            o_count <= i_inc ? `FSR_CNT_W'(1) : '0;
        end else if (i_inc && (o_count != '1)) begin
            o_count <= o_count + `FSR_CNT_W'(1);
        end
    end
endmodule
`default_nettype wire

// file: verilog/fsr_frame_status_reporter.sv
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defines.svh"

module fsr_frame_status_reporter (
    input wire logic i_clk, // 40 MHz client clock
    input wire logic i_rst, // synchronous, active high
    // apb slave
    input wire logic i_psel, // slave select
    input wire logic i_penable, // access phase
    input wire logic i_pwrite, // 1 write, 0 read
    input wire fsr_pkg::fsr_addr_t i_paddr, // byte address
    input wire fsr_pkg::fsr_data_t i_pwdata, // write data
    output fsr_pkg::fsr_data_t o_prdata, // read data
    output logic o_pready, // always ready
    output logic o_pslverr, // unmapped address
    // receive side of the mac
    input wire logic i_rx_eop, // end of frame pulse
    input wire logic i_rx_overflow, // receive overflow
    input wire logic i_rx_undersize, // frame too short
    input wire logic i_rx_oversize, // frame too long
    input wire logic i_rx_len_err, // payload length error
    input wire logic i_rx_crc_err, // crc error
    input wire logic i_rx_phy_err, // phy error
    // transmit side of the mac
    input wire logic i_tx_done, // frame sent pulse
    input wire fsr_pkg::fsr_len_t i_tx_payload_len, // payload length
    input wire fsr_pkg::fsr_len_t i_tx_packet_len, // packet length
    input wire fsr_pkg::fsr_type_t i_tx_type, // svlan..pfc, lsb first
    input wire logic i_tx_undersize, // frame too short
    input wire logic i_tx_oversize, // frame too long
    input wire logic i_tx_len_err, // payload length error
    input wire logic i_tx_underflow, // transmit underflow
    input wire logic i_tx_client_err, // client error
    input wire logic i_tx_crc_pad_ins, // crc/pad insertion on
    input wire fsr_pkg::fsr_queue_t i_pfc_xon_sent, // xon sent per queue
    input wire fsr_pkg::fsr_queue_t i_pfc_xoff_sent, // xoff sent per queue
    // client status outputs
    output logic o_rx_stream_last_beat, // rx end of packet
    output logic o_rx_frame_status_strobe, // rx status valid
    output fsr_pkg::fsr_err_vec_t o_rx_frame_error_vec, // rx errors
    output logic o_tx_frame_status_strobe, // tx status valid
    output fsr_pkg::fsr_tx_word_t o_tx_frame_status_word, // tx status
    output fsr_pkg::fsr_err_vec_t o_tx_frame_error_vec, // tx errors
    output logic o_tx_flowctl_status_strobe, // pfc status valid
    output fsr_pkg::fsr_pfc_vec_t o_tx_flowctl_status_vec, // xon/xoff
    output logic o_irq // level interrupt
);
    import fsr_pkg::*;

    function automatic fsr_reg_sel_t decode_addr(input fsr_addr_t addr);
        fsr_reg_sel_t sel;
        sel = FSR_SEL_NONE;
        case (addr)
            `FSR_OFS_CTRL: sel = FSR_SEL_CTRL;
            `FSR_OFS_IRQ_STAT: sel = FSR_SEL_IRQ_STAT;
            `FSR_OFS_IRQ_MASK: sel = FSR_SEL_IRQ_MASK;
            `FSR_OFS_RX_FRAMES: sel = FSR_SEL_RX_FRAMES;
            `FSR_OFS_RX_ERRORS: sel = FSR_SEL_RX_ERRORS;
            `FSR_OFS_TX_FRAMES: sel = FSR_SEL_TX_FRAMES;
            `FSR_OFS_TX_ERRORS: sel = FSR_SEL_TX_ERRORS;
            `FSR_OFS_LAST_LEN: sel = FSR_SEL_LAST_LEN;
            `FSR_OFS_LAST_ERR: sel = FSR_SEL_LAST_ERR;
            default: sel = FSR_SEL_NONE;
        endcase
        return sel;
    endfunction

    // lanes from twice the enabled queue count upward read as zero
    function automatic fsr_pfc_vec_t pfc_lane_mask(input logic [3:0] queues);
        fsr_pfc_vec_t mask;
        mask = '0;
        for (int k = 0; k < `FSR_PFC_QMAX; k++) begin
            if (k < int'(queues)) begin
                mask[2*k] = 1'b1;
                mask[2*k+1] = 1'b1;
            end
        end
        return mask;
    endfunction

    fsr_data_t ctrl;
    fsr_irq_t irq_status;
    fsr_irq_t irq_mask;
    fsr_reg_sel_t sel;
    logic bus_setup;
    logic bus_write;
    logic suppress_invalid;
    logic mask_on_overflow;
    logic [3:0] pfc_queues;
    fsr_err_vec_t next_rx_err;
    fsr_err_vec_t next_tx_err;
    fsr_tx_word_t next_tx_word;
    fsr_pfc_vec_t next_pfc_vec;
    logic tx_meaningful;
    logic next_tx_strobe;
    logic next_pfc_strobe;
    fsr_irq_t irq_set;
    fsr_irq_t irq_clr;
    fsr_cnt_t rx_frames;
    fsr_cnt_t rx_errors;
    fsr_cnt_t tx_frames;
    fsr_cnt_t tx_errors;
    logic clr_rx_frames;
    logic clr_rx_errors;
    logic clr_tx_frames;
    logic clr_tx_errors;

    assign sel = decode_addr(i_paddr);
    assign bus_setup = i_psel && !i_penable;
    assign bus_write = i_psel && i_penable && i_pwrite;
    // every access completes in its first access cycle
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && (sel == FSR_SEL_NONE);

    assign suppress_invalid = ctrl[`FSR_CTRL_SUPPRESS];
    assign mask_on_overflow = ctrl[`FSR_CTRL_OVF_MASK];
    // counts beyond the implemented queues are clamped
    assign pfc_queues = (ctrl[`FSR_CTRL_Q_LSB +: 4] > 4'h8) ? 4'h8
                      : ctrl[`FSR_CTRL_Q_LSB +: 4];

    always_comb begin
        next_rx_err = '0;
        next_rx_err[`FSR_RXE_UNDER] = i_rx_undersize;
        next_rx_err[`FSR_RXE_OVER] = i_rx_oversize;
        next_rx_err[`FSR_RXE_LEN] = i_rx_len_err;
        next_rx_err[`FSR_RXE_CRC] = i_rx_crc_err;
        next_rx_err[`FSR_RXE_PHY] = i_rx_phy_err;
        if (mask_on_overflow && i_rx_overflow) begin
            next_rx_err = '0;
        end
    end

    always_comb begin
        next_tx_err = '0;
        next_tx_err[`FSR_TXE_UNDER] = i_tx_undersize;
        next_tx_err[`FSR_TXE_OVER] = i_tx_oversize;
        next_tx_err[`FSR_TXE_LEN] = i_tx_len_err;
        next_tx_err[`FSR_TXE_UFLOW] = i_tx_underflow;
        next_tx_err[`FSR_TXE_CLIENT] = i_tx_client_err;
    end

    always_comb begin
        next_tx_word = '0;
        next_tx_word[`FSR_TXS_PAY_LSB +: `FSR_LEN_W] = i_tx_payload_len;
        next_tx_word[`FSR_TXS_PKT_LSB +: `FSR_LEN_W] = i_tx_packet_len;
        next_tx_word[`FSR_TXS_TYPE_LSB +: `FSR_TYPE_W] = i_tx_type;
    end

    assign tx_meaningful = !i_tx_underflow && !i_tx_crc_pad_ins;
    assign next_tx_strobe = i_tx_done && (tx_meaningful || !suppress_invalid);

    // even xon, odd xoff per queue
    always_comb begin
        next_pfc_vec = '0;
        for (int k = 0; k < `FSR_PFC_QMAX; k++) begin
            next_pfc_vec[2*k] = i_pfc_xon_sent[k];
            next_pfc_vec[2*k+1] = i_pfc_xoff_sent[k];
        end
        next_pfc_vec = next_pfc_vec & pfc_lane_mask(pfc_queues);
    end

    assign next_pfc_strobe = |next_pfc_vec;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rx_stream_last_beat <= 1'b0;
            o_rx_frame_status_strobe <= 1'b0;
        end else begin
            o_rx_stream_last_beat <= i_rx_eop;
            o_rx_frame_status_strobe <= i_rx_eop;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rx_frame_error_vec <= '0;
        end else if (i_rx_eop) begin
            o_rx_frame_error_vec <= next_rx_err;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_tx_frame_status_strobe <= 1'b0;
        end else begin
            o_tx_frame_status_strobe <= next_tx_strobe;
        end
    end

    // word and vector load with strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_tx_frame_status_word <= '0;
            o_tx_frame_error_vec <= '0;
        end else if (next_tx_strobe) begin
            o_tx_frame_status_word <= next_tx_word;
            o_tx_frame_error_vec <= next_tx_err;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_tx_flowctl_status_strobe <= 1'b0;
            o_tx_flowctl_status_vec <= '0;
        end else begin
            o_tx_flowctl_status_strobe <= next_pfc_strobe;
            if (next_pfc_strobe) begin
                o_tx_flowctl_status_vec <= next_pfc_vec;
            end
        end
    end

    // events seen one cycle before the matching output strobe
    always_comb begin
        irq_set = '0;
        irq_set[`FSR_IRQ_RX_FRAME] = i_rx_eop;
        irq_set[`FSR_IRQ_RX_ERROR] = i_rx_eop && (|next_rx_err);
        irq_set[`FSR_IRQ_RX_OVFL] = i_rx_overflow;
        irq_set[`FSR_IRQ_TX_FRAME] = next_tx_strobe;
        irq_set[`FSR_IRQ_TX_ERROR] = i_tx_done && (|next_tx_err);
        irq_set[`FSR_IRQ_TX_UFLOW] = i_tx_done && i_tx_underflow;
        irq_set[`FSR_IRQ_PFC] = next_pfc_strobe;
    end

    always_comb begin
        irq_clr = '0;
        if (bus_write && (sel == FSR_SEL_IRQ_STAT)) begin
            irq_clr = i_pwdata[`FSR_IRQ_W-1:0];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_mask <= `FSR_IRQ_MASK_RST;
        end else if (bus_write && (sel == FSR_SEL_IRQ_MASK)) begin
            irq_mask <= i_pwdata[`FSR_IRQ_W-1:0];
        end
    end

    // level output: stays high until software clears the cause
    assign o_irq = |(irq_status & irq_mask);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl <= `FSR_CTRL_RST;
        end else if (bus_write && (sel == FSR_SEL_CTRL)) begin
            ctrl <= i_pwdata & 32'h0000_00F3;
        end
    end

    // any write to a counter clears it
    assign clr_rx_frames = bus_write && (sel == FSR_SEL_RX_FRAMES);
    assign clr_rx_errors = bus_write && (sel == FSR_SEL_RX_ERRORS);
    assign clr_tx_frames = bus_write && (sel == FSR_SEL_TX_FRAMES);
    assign clr_tx_errors = bus_write && (sel == FSR_SEL_TX_ERRORS);

    fsr_evt_counter u_rx_frames (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clr(clr_rx_frames),
        .i_inc(irq_set[`FSR_IRQ_RX_FRAME]),
        .o_count(rx_frames)
    );

    fsr_evt_counter u_rx_errors (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clr(clr_rx_errors),
        .i_inc(irq_set[`FSR_IRQ_RX_ERROR]),
        .o_count(rx_errors)
    );

    // counts every sent frame, suppressed reports included
    fsr_evt_counter u_tx_frames (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clr(clr_tx_frames),
        .i_inc(i_tx_done),
        .o_count(tx_frames)
    );

    fsr_evt_counter u_tx_errors (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clr(clr_tx_errors),
        .i_inc(irq_set[`FSR_IRQ_TX_ERROR]),
        .o_count(tx_errors)
    );

    // read data captured in the setup cycle, shown in the access cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_prdata <= '0;
        end else if (bus_setup && !i_pwrite) begin
            o_prdata <= '0;
            case (sel)
                FSR_SEL_CTRL: o_prdata <= ctrl;
                FSR_SEL_IRQ_STAT: o_prdata[`FSR_IRQ_W-1:0] <= irq_status;
                FSR_SEL_IRQ_MASK: o_prdata[`FSR_IRQ_W-1:0] <= irq_mask;
                FSR_SEL_RX_FRAMES: o_prdata <= rx_frames;
                FSR_SEL_RX_ERRORS: o_prdata <= rx_errors;
                FSR_SEL_TX_FRAMES: o_prdata <= tx_frames;
                FSR_SEL_TX_ERRORS: o_prdata <= tx_errors;
                FSR_SEL_LAST_LEN: o_prdata <= o_tx_frame_status_word[31:0];
                FSR_SEL_LAST_ERR: begin
                    o_prdata[`FSR_ERR_W-1:0] <= o_rx_frame_error_vec;
                    o_prdata[`FSR_LERR_TX_LSB +: `FSR_ERR_W] <= o_tx_frame_error_vec;
                    o_prdata[`FSR_LERR_TYPE_LSB +: `FSR_TYPE_W] <=
                        o_tx_frame_status_word[`FSR_TXS_TYPE_LSB +: `FSR_TYPE_W];
                end
                default: o_prdata <= '0;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: tb/fsr_frame_status_reporter_props.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_frame_status_reporter_props (
    input wire logic i_clk, // clock
    input wire logic i_rst, // reset
    input wire logic i_rx_eop, // rx end
    input wire logic i_rx_overflow, // rx ovf
    input wire logic i_rx_undersize, // rx err
    input wire logic i_rx_oversize, // rx err
    input wire logic i_rx_len_err, // rx err
    input wire logic i_rx_crc_err, // rx err
    input wire logic i_rx_phy_err, // rx err
    input wire logic i_tx_done, // tx end
    input wire fsr_pkg::fsr_len_t i_tx_payload_len, // length
    input wire fsr_pkg::fsr_len_t i_tx_packet_len, // length
    input wire fsr_pkg::fsr_type_t i_tx_type, // types
    input wire logic i_tx_underflow, // tx err
    input wire logic i_tx_crc_pad_ins, // insertion
    input wire logic o_rx_stream_last_beat, // rx end
    input wire logic o_rx_frame_status_strobe, // rx valid
    input wire fsr_pkg::fsr_err_vec_t o_rx_frame_error_vec, // rx errors
    input wire logic o_tx_frame_status_strobe, // tx valid
    input wire fsr_pkg::fsr_tx_word_t o_tx_frame_status_word, // tx status
    input wire fsr_pkg::fsr_err_vec_t o_tx_frame_error_vec, // tx errors
    input wire logic o_tx_flowctl_status_strobe, // pfc valid
    input wire fsr_pkg::fsr_pfc_vec_t o_tx_flowctl_status_vec // xon/xoff
);
    import fsr_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_rx_eop_strobe: assert property (
        i_rx_eop |=> o_rx_frame_status_strobe && o_rx_stream_last_beat)
        else $error("rx strobe missing after frame end");
    a_rx_strobe_cause: assert property (
        o_rx_frame_status_strobe |-> $past(i_rx_eop) && o_rx_stream_last_beat)
        else $error("rx strobe without frame end");
    a_rx_vec_value: assert property (
        i_rx_eop && !i_rx_overflow |=> o_rx_frame_error_vec == {$past(i_rx_phy_err), 2'h0,
        $past(i_rx_crc_err), $past(i_rx_len_err), $past(i_rx_oversize), $past(i_rx_undersize)})
        else $error("rx error vector wrong");
    a_rx_one_pulse: assert property (
        o_rx_frame_status_strobe && !i_rx_eop |=> !o_rx_frame_status_strobe)
        else $error("rx strobe longer than one cycle");
    a_rx_vec_hold: assert property (
        !o_rx_frame_status_strobe && !$past(i_rst) |-> $stable(o_rx_frame_error_vec))
        else $error("rx error vector moved between strobes");
    a_tx_word_value: assert property (
        i_tx_done && !i_tx_underflow && !i_tx_crc_pad_ins |=> o_tx_frame_status_strobe &&
        o_tx_frame_status_word == {$past(i_tx_type), $past(i_tx_packet_len),
        $past(i_tx_payload_len)})
        else $error("tx status word wrong");
    a_tx_err_bits: assert property (
        i_tx_done |=> !o_tx_frame_status_strobe || (!o_tx_frame_error_vec[3] &&
        !o_tx_frame_error_vec[6] && o_tx_frame_error_vec[4] == $past(i_tx_underflow)))
        else $error("tx error vector wrong");
    a_tx_strobe_cause: assert property (
        o_tx_frame_status_strobe |-> $past(i_tx_done))
        else $error("tx strobe without sent frame");
    a_tx_word_hold: assert property (
        !o_tx_frame_status_strobe && !$past(i_rst) |-> $stable(o_tx_frame_status_word))
        else $error("tx word moved between strobes");
    a_pfc_strobe_vec: assert property (
        o_tx_flowctl_status_strobe |-> o_tx_flowctl_status_vec != 0)
        else $error("flow-control strobe with empty vector");
    a_pfc_vec_hold: assert property (
        !o_tx_flowctl_status_strobe && !$past(i_rst) |-> $stable(o_tx_flowctl_status_vec))
        else $error("flow-control vector moved between strobes");

    c_rx_err: cover property (o_rx_frame_status_strobe && o_rx_frame_error_vec != 0);
    c_rx_burst: cover property (o_rx_frame_status_strobe ##1 o_rx_frame_status_strobe);
    c_tx_strobe: cover property (o_tx_frame_status_strobe);
    c_pfc_strobe: cover property (o_tx_flowctl_status_strobe);
endmodule

bind fsr_frame_status_reporter fsr_frame_status_reporter_props u_props (
    .i_clk, .i_rst, .i_rx_eop, .i_rx_overflow, .i_rx_undersize, .i_rx_oversize,
    .i_rx_len_err, .i_rx_crc_err, .i_rx_phy_err, .i_tx_done, .i_tx_payload_len,
    .i_tx_packet_len, .i_tx_type, .i_tx_underflow, .i_tx_crc_pad_ins,
    .o_rx_stream_last_beat, .o_rx_frame_status_strobe, .o_rx_frame_error_vec,
    .o_tx_frame_status_strobe, .o_tx_frame_status_word, .o_tx_frame_error_vec,
    .o_tx_flowctl_status_strobe, .o_tx_flowctl_status_vec
);
`default_nettype wire

// file: tb/fsr_client_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_client_model (
    input wire logic i_clk, // client clock
    input wire logic i_rx_strobe, // rx valid
    input wire fsr_pkg::fsr_err_vec_t i_rx_vec, // rx errors
    input wire logic i_tx_strobe, // tx valid
    input wire fsr_pkg::fsr_tx_word_t i_tx_word, // tx status
    input wire fsr_pkg::fsr_err_vec_t i_tx_vec, // tx errors
    input wire logic i_pfc_strobe, // pfc valid
    input wire fsr_pkg::fsr_pfc_vec_t i_pfc_vec, // xon/xoff
    output logic o_rx_got, // rx taken
    output logic o_tx_got, // tx taken
    output logic o_pfc_got, // pfc taken
    output logic [63:0] o_rx_val, // rx status
    output logic [63:0] o_tx_val, // word and errors
    output logic [63:0] o_pfc_val // pfc status
);
    import fsr_pkg::*;
    always_ff @(posedge i_clk) begin
        o_rx_got <= i_rx_strobe;
        o_tx_got <= i_tx_strobe;
        o_pfc_got <= i_pfc_strobe;
        if (i_rx_strobe)
            o_rx_val <= {57'h0, i_rx_vec};
        if (i_tx_strobe)
            o_tx_val <= {17'h0, i_tx_word, i_tx_vec};
        if (i_pfc_strobe)
            o_pfc_val <= {48'h0, i_pfc_vec};
    end
endmodule
`default_nettype wire

// file: tb/fsr_frame_status_reporter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fsr_frame_status_reporter_tb_top;
    import fsr_pkg::*;
    logic i_clk = '0, i_rst = '1, i_psel = '0, i_penable = '0, i_pwrite = '0;
    fsr_addr_t i_paddr = '0;
    fsr_data_t i_pwdata = '0, o_prdata, rd;
    logic o_pready, o_pslverr, o_irq, err;
    logic i_rx_eop = '0, i_rx_overflow = '0, i_rx_undersize = '0, i_rx_oversize = '0;
    logic i_rx_len_err = '0, i_rx_crc_err = '0, i_rx_phy_err = '0, i_tx_done = '0;
    fsr_len_t i_tx_payload_len = '0, i_tx_packet_len = '0;
    fsr_type_t i_tx_type = '0;
    logic i_tx_undersize = '0, i_tx_oversize = '0, i_tx_len_err = '0, i_tx_underflow = '0;
    logic i_tx_client_err = '0, i_tx_crc_pad_ins = '0;
    fsr_queue_t i_pfc_xon_sent = '0, i_pfc_xoff_sent = '0;
    logic o_rx_stream_last_beat, o_rx_frame_status_strobe, o_tx_frame_status_strobe;
    logic o_tx_flowctl_status_strobe, rx_got, tx_got, pfc_got;
    fsr_err_vec_t o_rx_frame_error_vec, o_tx_frame_error_vec;
    fsr_tx_word_t o_tx_frame_status_word;
    fsr_pfc_vec_t o_tx_flowctl_status_vec;
    logic [63:0] rx_val, tx_val, pfc_val;
    logic [63:0] q_rx[$], q_tx[$], q_pfc[$];
    int n_mismatch = 0, total_checks = 0, n_eop, n_tx;
    integer seed = 32'h3F83;
    fsr_data_t modes[5] = '{32'h80, 32'h83, 32'h23, 32'h0, 32'h91};

    always #12.5 i_clk = ~i_clk;

    fsr_frame_status_reporter u_fsr_frame_status_reporter (
        .i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_rx_eop, .i_rx_overflow, .i_rx_undersize, .i_rx_oversize,
        .i_rx_len_err, .i_rx_crc_err, .i_rx_phy_err, .i_tx_done, .i_tx_payload_len,
        .i_tx_packet_len, .i_tx_type, .i_tx_undersize, .i_tx_oversize, .i_tx_len_err,
        .i_tx_underflow, .i_tx_client_err, .i_tx_crc_pad_ins, .i_pfc_xon_sent,
        .i_pfc_xoff_sent, .o_rx_stream_last_beat, .o_rx_frame_status_strobe,
        .o_rx_frame_error_vec, .o_tx_frame_status_strobe, .o_tx_frame_status_word,
        .o_tx_frame_error_vec, .o_tx_flowctl_status_strobe, .o_tx_flowctl_status_vec, .o_irq);

    fsr_client_model u_fsr_client_model (
        .i_clk, .i_rx_strobe(o_rx_frame_status_strobe), .i_rx_vec(o_rx_frame_error_vec),
        .i_tx_strobe(o_tx_frame_status_strobe), .i_tx_word(o_tx_frame_status_word),
        .i_tx_vec(o_tx_frame_error_vec), .i_pfc_strobe(o_tx_flowctl_status_strobe),
        .i_pfc_vec(o_tx_flowctl_status_vec), .o_rx_got(rx_got), .o_tx_got(tx_got),
        .o_pfc_got(pfc_got), .o_rx_val(rx_val), .o_tx_val(tx_val), .o_pfc_val(pfc_val));

    task automatic chk(input logic [62:0] seen, input logic [62:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic take(ref logic [63:0] q[$], input logic [63:0] v);
        logic [63:0] e;
        if (q.size() == 0) begin
            n_mismatch++;
            $display("BAD %0t status with nothing expected", $time);
        end else begin
            e = q.pop_front();
            if (e[63])
                chk(v[62:0], e[62:0]);
        end
    endtask

    task automatic apb(input logic wr, input fsr_addr_t a, input fsr_data_t d);
        @(posedge i_clk);
        i_psel <= 1'h1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'h1;
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'h1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask

    // one cycle of mac events; void frames are noted but not compared
    task automatic drive(input logic [63:0] r, input fsr_data_t ctrl);
        fsr_pfc_vec_t pv;
        logic vd;
        int nq;
        @(posedge i_clk);
        i_rx_eop <= r[0];
        i_rx_overflow <= r[1] & r[2];
        {i_rx_phy_err, i_rx_crc_err, i_rx_len_err, i_rx_oversize, i_rx_undersize} <= r[7:3];
        i_tx_done <= r[8];
        {i_tx_client_err, i_tx_underflow, i_tx_len_err, i_tx_oversize, i_tx_undersize} <= r[13:9];
        i_tx_crc_pad_ins <= r[14] & r[15];
        i_pfc_xon_sent <= r[23:16] & {8{r[24]}};
        i_pfc_xoff_sent <= r[32:25] & {8{r[24]}};
        i_tx_type <= r[40:33];
        i_tx_payload_len <= r[56:41];
        i_tx_packet_len <= r[63:48];
        n_eop += r[0];
        n_tx += r[8];
        if (r[0])
            q_rx.push_back({!(r[1] & r[2] & !ctrl[1]), 56'h0,
                (r[1] & r[2] & ctrl[1]) ? 7'h0 : {r[7], 2'h0, r[6:3]}});
        vd = r[12] | (r[14] & r[15]);
        if (r[8] && !(ctrl[0] && vd))
            q_tx.push_back({!vd, 16'h0, r[40:33], r[63:48], r[56:41], 1'h0, r[13:12], 1'h0, r[11:9]});
        nq = (ctrl[7:4] > 8) ? 8 : int'(ctrl[7:4]);
        pv = '0;
        for (int k = 0; k < nq; k++) begin
            pv[2*k] = r[16+k] & r[24];
            pv[2*k+1] = r[25+k] & r[24];
        end
        if (pv != 0)
            q_pfc.push_back({1'h1, 47'h0, pv});
    endtask

    always @(posedge i_clk) begin
        if (rx_got)
            take(q_rx, rx_val); // rx vector
        if (tx_got)
            take(q_tx, tx_val); // tx word
        if (pfc_got)
            take(q_pfc, pfc_val); // flow vector
    end

    task automatic print_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        print_verdict;
    end

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'h0;
        apb(1'h0, 8'h00, '0);
        chk(rd, 32'h80);
        apb(1'h0, 8'h08, '0);
        chk(rd, 32'h0);
        apb(1'h0, 8'h40, '0);
        chk({rd, err}, 33'h1);
        foreach (modes[m]) begin
            apb(1'h1, 8'h00, modes[m]);
            apb(1'h1, 8'h0C, '0);
            apb(1'h1, 8'h14, '0);
            n_eop = 0;
            n_tx = 0;
            for (int i = 0; i < 40; i++)
                drive({$random(seed), $random(seed)}, modes[m]);
            drive('0, modes[m]);
            apb(1'h0, 8'h0C, '0);
            chk(rd, n_eop); // one count per frame end
            apb(1'h0, 8'h14, '0);
            chk(rd, n_tx); // one count per sent frame
        end
        apb(1'h1, 8'h04, 32'h7F);
        drive(64'h100, 32'h91);
        drive('0, 32'h91);
        apb(1'h0, 8'h04, '0);
        chk(rd, 32'h8); // tx strobe event
        @(negedge i_clk);
        chk(o_irq, 1'h0);
        apb(1'h1, 8'h08, 32'h8);
        @(negedge i_clk);
        chk(o_irq, 1'h1);
        apb(1'h1, 8'h04, 32'h8);
        @(negedge i_clk);
        chk(o_irq, 1'h0);
        repeat (4) @(posedge i_clk);
        chk(q_rx.size() + q_tx.size() + q_pfc.size(), 0); // no lost strobe
        print_verdict;
    end
endmodule
`default_nettype wire
